// >>> design/nmi_pkg.sv
`include "nmi_regs.svh"
package nmi_pkg;
    // Source that won the priority decode
    typedef enum logic [1:0] {
        nmi_src_conv = 2'b00,
        nmi_src_tmr0 = 2'b01,
        nmi_src_tmr1 = 2'b10,
        nmi_src_port = 2'b11
    } nmi_src_e;

    // One register port request
    typedef struct packed {
        logic [`NMI_ADDR_W-1:0] addr;
        logic [3:0] wdata;
        logic wr;
        logic rd;
    } nmi_bus_s;

    // Context pushed on entry
    typedef struct packed {
        logic [`NMI_PC_W-1:0] pc;
        logic carry;
    } nmi_push_s;
endpackage

// >>> design/nmi_regs.svh
`ifndef NMI_REGS_SVH
`define NMI_REGS_SVH
// Behaviour
// R1: Four sources: converter, timer0, timer1, port edges
// R2: Enables at offset 0, requests at 1
// R3: Reset clears all enables and all requests
// R4: Take when request and enable; fixed priority
// R5: Push program counter and carry, then branch
// R6: Entry clears all four global enables
// R7: Enables rewritten in service allow nesting
// R8: After enabling, entry follows two more instructions
// R9: Flag cleared in those two abandons entry
// R10: Conversion done sets converter request, enable bit3
// R11: Enabled converter interrupt wakes core from HALT
// R12: Timer rollover sets its request flag
// R13: Enabled timer interrupt wakes core from HALT
// R14: Analog configured pins never raise port requests
// R15: Enabled port interrupt wakes HALT or STOP
// R16: Per-pin enable registers, one per port
// R17: Per-pin request flags set by falling edge
// R18: Enabled per-pin request sets global port request
// R19: Requests stay until written zero; set wins

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NMI_ADDR_W 10
`define NMI_OFS_EN 10'h000
`define NMI_OFS_REQ 10'h001
`define NMI_OFS_PD_EN 10'h384
`define NMI_OFS_PD_REQ 10'h385
`define NMI_OFS_PB_EN 10'h386
`define NMI_OFS_PB_REQ 10'h387

// ----------------------------------------
// Field positions, reset values, counts
// ----------------------------------------
`define NMI_BIT_CONV 3
`define NMI_BIT_TMR0 2
`define NMI_BIT_TMR1 1
`define NMI_BIT_PORT 0
`define NMI_RST_NIB 4'h0
`define NMI_PC_W 12
`define NMI_ENTRY_WAIT 2'h2
`endif

// >>> design/nmi_top.sv
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "nmi_regs.svh"
module nmi_top (
    // Clock and reset
    input logic core_clk,
    input logic rstn,
    // Register port
    input nmi_pkg::nmi_bus_s bus_req,
    output logic [3:0] bus_rdata,
    // Internal event pulses
    input logic adc_done,
    input logic t0_overflow,
    input logic t1_overflow,
    // Port pins and their analog selection
    input logic [3:0] edge_port_d,
    input logic [3:0] edge_port_b,
    input logic [3:0] port_d_analog,
    input logic [3:0] port_b_analog,
    // Core status
    input logic instr_done,
    input logic cpu_halted,
    input logic cpu_stopped,
    input logic [`NMI_PC_W-1:0] cpu_pc,
    input logic carry_flag,
    // Core requests
    output logic irq_take,
    output nmi_pkg::nmi_src_e irq_vector,
    output nmi_pkg::nmi_push_s stack_push,
    output logic cpu_wake
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Address match, shared by read and write decode
    function automatic logic hit(input logic [`NMI_ADDR_W-1:0] a,
                                 input logic [`NMI_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Fixed priority: converter first, port last
    function automatic nmi_pkg::nmi_src_e prio(input logic [3:0] p);
        if (p[`NMI_BIT_CONV]) begin
            prio = nmi_pkg::nmi_src_conv;
        end else if (p[`NMI_BIT_TMR0]) begin
            prio = nmi_pkg::nmi_src_tmr0;
        end else if (p[`NMI_BIT_TMR1]) begin
            prio = nmi_pkg::nmi_src_tmr1;
        end else begin
            prio = nmi_pkg::nmi_src_port;
        end
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------

    logic rst_meta_n_r; // First reset stage
    logic rst_sync_n_r; // Released reset for the rest

    // Assert at once, release two edges later
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_n_r <= 1'b1;
            rst_sync_n_r <= rst_meta_n_r;
        end
    end

    // ----------------------------------------
    // Declarations
    // ----------------------------------------

    logic [3:0] en_r; // Global enables
    logic [3:0] req_r; // Global requests
    logic [3:0] pending; // Enabled and requested
    logic any_pending; // Something to take
    logic [1:0] wait_r; // Instructions left before entry
    logic take_now; // Entry this cycle
    logic irq_take_r; // Registered entry pulse
    nmi_pkg::nmi_src_e irq_vector_r; // Registered vector
    nmi_pkg::nmi_push_s stack_push_r; // Registered context
    logic cpu_wake_r; // Registered wake
    logic [3:0] bus_rdata_r; // Registered read data
    logic en_wr; // Write to enables
    logic req_wr; // Write to requests
    logic en_arm; // Enable write that opens a new entry
    logic [3:0] events; // Hardware set pulses
    logic [1:0][3:0] pin_in; // Raw pins, index 0 is port D
    logic [1:0][3:0] pin_analog; // Analog selection per pin
    logic [1:0][3:0] pin_meta_r; // Pin sync stage one
    logic [1:0][3:0] pin_sync_r; // Pin sync stage two
    logic [1:0][3:0] pin_prev_r; // Last synced level
    logic [1:0][3:0] pin_fall; // Digital falling edges
    logic [1:0][3:0] pin_en_r; // Per-pin enables
    logic [1:0][3:0] pin_req_r; // Per-pin requests
    logic [1:0] pin_req_wr; // Write to per-pin requests
    logic port_cond; // Any enabled per-pin request
    logic port_cond_r; // Last value of port_cond
    logic port_set; // New port request

    assign pin_in = {edge_port_b, edge_port_d};
    assign pin_analog = {port_b_analog, port_d_analog};
    assign en_wr = bus_req.wr && hit(bus_req.addr, `NMI_OFS_EN);
    assign req_wr = bus_req.wr && hit(bus_req.addr, `NMI_OFS_REQ);

    // ----------------------------------------
    // Port edge detection
    // ----------------------------------------

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            localparam logic [`NMI_ADDR_W-1:0] EN_OFS = (p == 0) ? `NMI_OFS_PD_EN
                                                                 : `NMI_OFS_PB_EN;
            localparam logic [`NMI_ADDR_W-1:0] REQ_OFS = (p == 0) ? `NMI_OFS_PD_REQ
                                                                  : `NMI_OFS_PB_REQ;

            // Pins are asynchronous, so two stages before any use
            always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
                if (!rst_sync_n_r) begin
                    pin_meta_r[p] <= `NMI_RST_NIB;
                    pin_sync_r[p] <= `NMI_RST_NIB;
                    pin_prev_r[p] <= `NMI_RST_NIB;
                end else begin
                    pin_meta_r[p] <= pin_in[p];
                    pin_sync_r[p] <= pin_meta_r[p];
                    pin_prev_r[p] <= pin_sync_r[p];
                end
            end

            // Analog pins are masked off the edge detector
            assign pin_fall[p] = pin_prev_r[p] & ~pin_sync_r[p] & ~pin_analog[p]; // [R14]
            assign pin_req_wr[p] = bus_req.wr && hit(bus_req.addr, REQ_OFS);

            // Per-pin enables, plain storage
            always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
                if (!rst_sync_n_r) begin
                    pin_en_r[p] <= `NMI_RST_NIB;
                end else if (bus_req.wr && hit(bus_req.addr, EN_OFS)) begin
                    pin_en_r[p] <= bus_req.wdata; // [R16]
                end
            end

            // Per-pin requests; an edge beats a clearing write
            always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
                if (!rst_sync_n_r) begin
                    pin_req_r[p] <= `NMI_RST_NIB;
                end else if (pin_req_wr[p]) begin
                    pin_req_r[p] <= bus_req.wdata | pin_fall[p]; // [R17] [R19]
                end else begin
                    pin_req_r[p] <= pin_req_r[p] | pin_fall[p]; // [R17]
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Global port request
    // ----------------------------------------

    // Rising edge only, so software can clear the global flag
    assign port_cond = |((pin_req_r[0] & pin_en_r[0]) | (pin_req_r[1] & pin_en_r[1]));
    assign port_set = port_cond && !port_cond_r; // [R18]

    // Remember the previous condition
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            port_cond_r <= 1'b0;
        end else begin
            port_cond_r <= port_cond;
        end
    end

    // ----------------------------------------
    // Global enables and requests
    // ----------------------------------------

    // Source pulses into their bit positions
    always_comb begin
        events = `NMI_RST_NIB;
        events[`NMI_BIT_CONV] = adc_done; // [R1] [R10]
        events[`NMI_BIT_TMR0] = t0_overflow; // [R12]
        events[`NMI_BIT_TMR1] = t1_overflow; // [R12]
        events[`NMI_BIT_PORT] = port_set; // [R1]
    end

    // Requests: events win over a write of zero
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            req_r <= `NMI_RST_NIB; // [R3]
        end else if (req_wr) begin
            req_r <= bus_req.wdata | events; // [R2] [R19]
        end else begin
            req_r <= req_r | events; // [R10] [R12]
        end
    end

    // Enables: entry clears all, which beats a same-cycle write
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            en_r <= `NMI_RST_NIB; // [R3]
        end else if (take_now) begin
            en_r <= `NMI_RST_NIB; // [R6]
        end else if (en_wr) begin
            en_r <= bus_req.wdata; // [R2] [R7]
        end
    end

    assign pending = req_r & en_r; // [R4]
    assign any_pending = |pending;

    // ----------------------------------------
    // Entry delay after enabling
    // ----------------------------------------

    // Only a write that opens a new source restarts the delay
    assign en_arm = en_wr && !take_now && |(bus_req.wdata & req_r & ~en_r);

    // Count the enabling instruction and the two after it
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            wait_r <= 2'h0;
        end else if (en_arm) begin
            wait_r <= instr_done ? `NMI_ENTRY_WAIT : `NMI_ENTRY_WAIT + 2'h1; // [R8]
        end else if (instr_done && wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1; // [R8]
        end
    end

    // Entry at an instruction boundary, or at once in HALT or STOP; a dropped flag abandons it
    assign take_now = any_pending && !irq_take_r &&
                      (cpu_halted || cpu_stopped || (instr_done && wait_r <= 2'h1)); // [R8] [R9]

    // ----------------------------------------
    // Entry outputs
    // ----------------------------------------

    // One pulse per entry
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            irq_take_r <= 1'b0;
        end else begin
            irq_take_r <= take_now; // [R4]
        end
    end

    // Vector and saved context are held until the next entry
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            irq_vector_r <= nmi_pkg::nmi_src_conv;
            stack_push_r <= '0;
        end else if (take_now) begin
            irq_vector_r <= prio(pending); // [R4]
            stack_push_r <= {cpu_pc, carry_flag}; // [R5]
        end
    end

    // Wake: any enabled source from HALT, port only from STOP
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            cpu_wake_r <= 1'b0;
        end else begin
            cpu_wake_r <= (cpu_halted && any_pending) || // [R11] [R13] [R15]
                          (cpu_stopped && pending[`NMI_BIT_PORT]); // [R15]
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------

    // Data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            bus_rdata_r <= `NMI_RST_NIB;
        end else if (!bus_req.rd) begin
            bus_rdata_r <= `NMI_RST_NIB;
        end else if (hit(bus_req.addr, `NMI_OFS_EN)) begin
            bus_rdata_r <= en_r; // [R2]
        end else if (hit(bus_req.addr, `NMI_OFS_REQ)) begin
            bus_rdata_r <= req_r; // [R2]
        end else if (hit(bus_req.addr, `NMI_OFS_PD_EN)) begin
            bus_rdata_r <= pin_en_r[0]; // [R16]
        end else if (hit(bus_req.addr, `NMI_OFS_PD_REQ)) begin
            bus_rdata_r <= pin_req_r[0]; // [R17]
        end else if (hit(bus_req.addr, `NMI_OFS_PB_EN)) begin
            bus_rdata_r <= pin_en_r[1]; // [R16]
        end else if (hit(bus_req.addr, `NMI_OFS_PB_REQ)) begin
            bus_rdata_r <= pin_req_r[1]; // [R17]
        end else begin
            bus_rdata_r <= `NMI_RST_NIB; // Unmapped reads as zero
        end
    end

    assign bus_rdata = bus_rdata_r;
    assign irq_take = irq_take_r;
    assign irq_vector = irq_vector_r;
    assign stack_push = stack_push_r;
    assign cpu_wake = cpu_wake_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_sync_n_r);

    // Enabling write, nothing pending yet and nothing retiring in that cycle
    sequence arm_s;
        en_arm && !any_pending && !instr_done && !cpu_halted && !cpu_stopped;
    endsequence

    // Two further cycles with no instruction retiring
    sequence idle2_s;
        (!instr_done && !cpu_halted && !cpu_stopped)[*2];
    endsequence

    reset_clear_a: assert property ($rose(rst_sync_n_r) |-> en_r == 4'h0 && req_r == 4'h0) // [R3]
        else $error("flags not clear after reset");

    take_cause_a: assert property (irq_take |-> $past(any_pending)) // [R4]
        else $error("entry without enabled request");

    conv_prio_a: assert property (irq_take && $past(pending[`NMI_BIT_CONV])
                                  |-> irq_vector == nmi_pkg::nmi_src_conv) // [R4]
        else $error("converter lost priority");

    push_ctx_a: assert property (irq_take |-> stack_push.pc == $past(cpu_pc) &&
                                 stack_push.carry == $past(carry_flag)) // [R5]
        else $error("wrong context pushed");

    en_clear_a: assert property (irq_take |-> en_r == 4'h0) // [R6]
        else $error("enables survive entry");

    // The enabling instruction's own retirement, the first after the write, must not enter yet
    entry_delay_a: assert property (arm_s ##1 idle2_s ##1 // [R8]
                                    (instr_done && !cpu_halted && !cpu_stopped)
                                    |=> !irq_take)
        else $error("entry before two instructions");

    // A write that drops every enabled request cancels the coming entry
    abandon_a: assert property (req_wr && ((bus_req.wdata | events) & en_r) == 4'h0 // [R9]
                                |-> ##2 !irq_take)
        else $error("entry after flag cleared");

    set_wins_a: assert property (adc_done |=> req_r[`NMI_BIT_CONV]) // [R10]
        else $error("converter event lost");

    tmr_set_a: assert property (t0_overflow |=> req_r[`NMI_BIT_TMR0]) // [R12]
        else $error("timer event lost");

    wake_halt_a: assert property (cpu_halted && (pending[`NMI_BIT_CONV] ||
                                  pending[`NMI_BIT_TMR0]) |=> cpu_wake) // [R11] [R13]
        else $error("no wake from halt");

    wake_stop_a: assert property (cpu_stopped && !cpu_halted && !pending[`NMI_BIT_PORT]
                                  |=> !cpu_wake) // [R15]
        else $error("stop woken by non-port source");

    analog_mask_a: assert property (&port_b_analog && !pin_req_wr[1]
                                    |=> pin_req_r[1] == $past(pin_req_r[1])) // [R14]
        else $error("analog pin raised request");

    wake_port_a: assert property (cpu_stopped && pending[`NMI_BIT_PORT] |=> cpu_wake) // [R15]
        else $error("no wake from stop");

    tmr1_set_a: assert property (t1_overflow |=> req_r[`NMI_BIT_TMR1]) // [R12]
        else $error("timer one event lost");

    read_idle_a: assert property (!bus_req.rd |=> bus_rdata == 4'h0) // [R2]
        else $error("read data outside its cycle");

    nest_open_a: assert property (en_wr && !take_now |=> en_r == $past(bus_req.wdata)) // [R7]
        else $error("enable write lost");

endmodule // nmi_top

// >>> verification/nmi_core_model.sv
`timescale 1ns/10ps
`include "nmi_regs.svh"
// ----------------------------------------
// Core model: retires one instruction every GAP clocks
// ----------------------------------------
module nmi_core_model #(
    parameter int GAP = 5
) (
    // Clock and reset
    input logic core_clk,
    input logic rstn,
    // Low-power levels set by the bench
    input logic halt,
    input logic stop,
    // Entry from the block
    input logic irq_take,
    // Core status
    output logic instr_done,
    output logic cpu_halted,
    output logic cpu_stopped,
    output logic [`NMI_PC_W-1:0] cpu_pc,
    output logic carry_flag
);
    logic [7:0] tick_r; // Cycle count inside one instruction

    // A sleeping core retires nothing, so the entry delay freezes too
    assign cpu_halted = halt;
    assign cpu_stopped = stop;

    // Instruction stream with a moving PC and carry
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tick_r <= 8'h00;
            instr_done <= 1'b0;
            cpu_pc <= 12'h100;
            carry_flag <= 1'b0;
        end else begin
            tick_r <= (tick_r == 8'(GAP - 1)) ? 8'h00 : tick_r + 8'h01;
            instr_done <= (tick_r == 8'h00) && !halt && !stop;
            // Vector fetch moves the PC away from the stream
            if (irq_take) begin
                cpu_pc <= 12'h010;
            end else if (instr_done) begin
                cpu_pc <= cpu_pc + 12'h001;
            end
            if (instr_done) begin
                carry_flag <= ~carry_flag;
            end
        end
    end
endmodule // nmi_core_model

// >>> verification/test_nibble_mcu_interrupt_logic.sv
`timescale 1ns/10ps
`include "nmi_regs.svh"
module test_nibble_mcu_interrupt_logic;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    nmi_pkg::nmi_bus_s bus_req = '0;
    logic adc_done = 1'b0, t0_overflow = 1'b0, t1_overflow = 1'b0;
    // Pins start high so the first low level is a real edge
    logic [3:0] edge_port_d = 4'hF, edge_port_b = 4'hF;
    logic [3:0] port_d_analog = 4'h0, port_b_analog = 4'h0;
    logic halt = 1'b0, stop = 1'b0;
    logic instr_done, cpu_halted, cpu_stopped, carry_flag, irq_take, cpu_wake;
    logic [`NMI_PC_W-1:0] cpu_pc;
    logic [3:0] bus_rdata;
    nmi_pkg::nmi_src_e irq_vector;
    nmi_pkg::nmi_push_s stack_push;
    int fails = 0, checks = 0, cyc = 0;
    logic [3:0] rq[$]; // Expected read data
    logic [5:0] eq[$]; // Expected entries: vector code, instructions since enable
    logic [5:0] ent;
    logic rdv = 1'b0;
    logic [3:0] ndone = 4'h0, r;
    logic [`NMI_PC_W:0] ctx;
    logic [9:0] ofs [6] = '{`NMI_OFS_EN, `NMI_OFS_REQ, `NMI_OFS_PD_EN,
        `NMI_OFS_PD_REQ, `NMI_OFS_PB_EN, `NMI_OFS_PB_REQ};

    nmi_top i_dut (.core_clk, .rstn, .bus_req, .bus_rdata, .adc_done, .t0_overflow,
        .t1_overflow, .edge_port_d, .edge_port_b, .port_d_analog, .port_b_analog,
        .instr_done, .cpu_halted, .cpu_stopped, .cpu_pc, .carry_flag, .irq_take,
        .irq_vector, .stack_push, .cpu_wake);
    nmi_core_model i_core (.core_clk, .rstn, .halt, .stop, .irq_take, .instr_done,
        .cpu_halted, .cpu_stopped, .cpu_pc, .carry_flag);

    initial forever #10 core_clk = ~core_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [3:0] d);
        @(posedge core_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [3:0] e);
        rq.push_back(e);
        @(posedge core_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
    endtask

    // One-cycle pulses of converter, timer 0, timer 1
    task automatic ev(input logic [2:0] m);
        @(posedge core_clk);
        {adc_done, t0_overflow, t1_overflow} <= m;
        @(posedge core_clk);
        {adc_done, t0_overflow, t1_overflow} <= 3'b000;
    endtask

    // Write the given enables and expect one entry, enables cleared after it
    task automatic enter(input logic [3:0] en, input logic [5:0] e);
        eq.push_back(e);
        wr(`NMI_OFS_EN, en);
        idle(25);
        rd(`NMI_OFS_EN, 4'h0);
    endtask

    // Sleep the core, open a source and watch the wake line
    task automatic wake(input logic h, input logic s, input logic [3:0] en,
        input logic [5:0] e, input logic w);
        logic seen;
        seen = 1'b0;
        @(posedge core_clk);
        halt <= h;
        stop <= s;
        idle(3);
        eq.push_back(e);
        wr(`NMI_OFS_EN, en);
        repeat (6) @(negedge core_clk) seen |= cpu_wake;
        chk(seen, w);
        @(posedge core_clk);
        halt <= 1'b0;
        stop <= 1'b0;
        idle(10);
    endtask

    // ----------------------------------------
    // Output watcher: reads and entries against the notes
    // ----------------------------------------
    always @(posedge core_clk) begin
        cyc++;
        rdv <= bus_req.rd;
        ctx <= {cpu_pc, carry_flag};
        // Instructions retired since the enabling write, that write included
        if (bus_req.wr && bus_req.addr == `NMI_OFS_EN) ndone <= {3'h0, instr_done};
        else ndone <= ndone + {3'h0, instr_done};
        if (cyc == 6000) begin
            fails++;
            complete_run;
        end
    end

    always @(negedge core_clk) begin
        if (rdv && rq.size() > 0) chk(bus_rdata, rq.pop_front());
        if (irq_take === 1'b1) begin
            if (eq.size() == 0) chk(1'b1, 1'b0);
            else begin
                ent = eq.pop_front();
                chk(irq_vector, ent[5:4]);
                chk(stack_push, ctx);
                chk(ndone, ent[3:0]);
            end
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hc319));
        idle(12);
        rstn <= 1'b1;
        idle(3);
        for (int i = 0; i < 6; i++) rd(ofs[i], 4'h0);
        rd(10'h002, 4'h0);
        r = 4'($urandom);
        wr(`NMI_OFS_EN, r);
        rd(`NMI_OFS_EN, r);
        wr(`NMI_OFS_EN, 4'h0);
        for (int i = 2; i < 6; i++) begin
            r = 4'($urandom);
            wr(ofs[i], r);
            rd(ofs[i], r);
        end
        for (int i = 2; i < 6; i++) wr(ofs[i], 4'h0);
        wr(`NMI_OFS_REQ, 4'h0);
        rd(`NMI_OFS_REQ, 4'h0);
        // Pin edges with analog masking, then internal events
        port_b_analog <= 4'hF;
        wr(`NMI_OFS_PD_EN, 4'h1);
        wr(`NMI_OFS_PB_EN, 4'hF);
        edge_port_d <= 4'hC;
        edge_port_b <= 4'h0;
        ev(3'b111);
        idle(8);
        rd(`NMI_OFS_PD_REQ, 4'h3);
        rd(`NMI_OFS_PB_REQ, 4'h0);
        rd(`NMI_OFS_REQ, 4'hF);
        // Each source alone, re-enabled from inside the last service
        for (int b = 3; b >= 0; b--) enter(4'h1 << b, {2'(3 - b), 4'h3});
        enter(4'hF, 6'h03);
        // Request withdrawn between the enabling write and the entry
        wr(`NMI_OFS_REQ, 4'h0);
        ev(3'b100);
        wr(`NMI_OFS_EN, 4'h8);
        @(negedge core_clk);
        for (int k = 0; k < 20 && instr_done !== 1'b1; k++) @(negedge core_clk);
        wr(`NMI_OFS_REQ, 4'h0);
        idle(30);
        wr(`NMI_OFS_EN, 4'h0);
        // Fresh pin edge and events for the wake cases
        wr(`NMI_OFS_PD_REQ, 4'h0);
        edge_port_d <= 4'hF;
        idle(4);
        edge_port_d <= 4'hC;
        ev(3'b111);
        idle(8);
        wake(1'b1, 1'b0, 4'h8, 6'h00, 1'b1);
        wake(1'b1, 1'b0, 4'h4, 6'h10, 1'b1);
        wake(1'b0, 1'b1, 4'h8, 6'h00, 1'b0);
        wake(1'b0, 1'b1, 4'h1, 6'h30, 1'b1);
        idle(5);
        chk(eq.size() == 0, 1'b1);
        complete_run;
    end
endmodule // test_nibble_mcu_interrupt_logic
